// ===== include/pmd_pkg.sv
package pmd_pkg;
	// Address widths
	localparam int ADDR_W = 24;
	localparam int EXT_W  = 20;
	// Page numbers
	localparam logic [7:0] PAGE_00 = 8'h00;
	localparam logic [7:0] PAGE_FF = 8'hff;
	// Program and special-purpose partition (low 16 bits within a page)
	localparam logic [15:0] PART_LO    = 16'h2000;
	localparam logic [15:0] PART_HI    = 16'h9fff;
	localparam logic [15:0] SPECIAL_HI = 16'h207f;
	// Page FFH external and code RAM ranges
	localparam logic [15:0] EXTA_LO = 16'h0100;
	localparam logic [15:0] EXTA_HI = 16'h03ff;
	localparam logic [15:0] CRAM_LO = 16'h0400;
	localparam logic [15:0] CRAM_HI = 16'h05ff;
	localparam logic [15:0] EXTB_LO = 16'h0600;
	localparam logic [15:0] EXTB_HI = 16'h1fff;
	// Special-function register regions
	localparam logic [15:0] PSFR_LO = 16'h1f00;
	localparam logic [15:0] PSFR_HI = 16'h1fdf;
	localparam logic [15:0] MSFR_LO = 16'h1fe0;
	localparam logic [15:0] MSFR_HI = 16'h1fff;
	// Special-purpose content
	localparam logic [15:0] LVEC_LO = 16'h2000;
	localparam logic [15:0] UVEC_LO = 16'h2030;
	localparam logic [15:0] TVEC_LO = 16'h2040;
	localparam logic [15:0] TVEC_HI = 16'h205d;
	localparam logic [15:0] KEY_LO  = 16'h2020;
	localparam logic [15:0] KEY_HI  = 16'h202f;
	// Configuration byte addresses and the otp_select_a bit position
	localparam logic [23:0] CFG0_ADDR = 24'hff2018;
	localparam logic [23:0] CFG1_ADDR = 24'hff201a;
	localparam logic [23:0] CFG2_ADDR = 24'hff201c;
	localparam int          OTP_SELECT_A_BIT = 2;
	// Code RAM control register, window read fill and configuration reset value
	localparam logic [15:0] CRC_ADDR      = 16'h1fe0;
	localparam int          CRC_EASTAT    = 7;
	localparam int          CRC_DISABLE   = 6;
	localparam logic [7:0]  CRC_RESET     = 8'h00;
	localparam logic [7:0]  WINDOW_FILL   = 8'hff;
	localparam logic [7:0]  CFG_RESET     = 8'hff;

	// Access target
	typedef enum logic [3:0] {
		TGT_EXT  = 4'b0001,
		TGT_OTP  = 4'b0010,
		TGT_CRAM = 4'b0100,
		TGT_SFR  = 4'b1000
	} target_t;

	// CPU request
	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic              extended;
		logic              window;
		logic              write;
		logic              word;
		logic [7:0]        wdata;
	} cpu_req_t;

	// Routed access
	typedef struct packed {
		target_t           target;
		logic [EXT_W-1:0]  ext_addr;
		logic [ADDR_W-1:0] otp_addr;
		logic              blocked;
		logic              key_area;
		logic              vector_area;
	} route_t;
endpackage : pmd_pkg

// ===== logic/addr_router.sv
`timescale 1ns/1ps
// Combinational address decode for one CPU request
module addr_router (
	// Request and setup
	input  pmd_pkg::cpu_req_t req,
	input  wire logic         has_otp,
	input  wire logic         ext_active,
	input  wire logic         otp_select_a,
	input  wire logic         cram_dis,
	// Decision
	output pmd_pkg::route_t   route
);
	// Range test used by every region
	function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
			input logic [15:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	wire logic [7:0]  page  = req.addr[23:16];
	wire logic [15:0] low   = req.addr[15:0];
	wire logic        pg_ff = (page == pmd_pkg::PAGE_FF);
	wire logic        pg_00 = (page == pmd_pkg::PAGE_00);
	// Partition hits in page FFH and in the page 00H copy
	wire logic        part_ff = pg_ff && in_rng(low, pmd_pkg::PART_LO, pmd_pkg::PART_HI); // R1
	wire logic        part_00 = pg_00 && in_rng(low, pmd_pkg::PART_LO, pmd_pkg::PART_HI);
	wire logic        cram_hit = (pg_ff || pg_00)
		&& in_rng(low, pmd_pkg::CRAM_LO, pmd_pkg::CRAM_HI); // R6
	wire logic        psfr = pg_00 && in_rng(low, pmd_pkg::PSFR_LO, pmd_pkg::PSFR_HI); // R17
	wire logic        msfr = pg_00 && in_rng(low, pmd_pkg::MSFR_LO, pmd_pkg::MSFR_HI); // R19
	// Internal store serves: no pin override, part fitted
	wire logic        otp_ok = has_otp && !ext_active; // R2
	// FF page always internal when served; 00H copy only for plain fetches with otp_select_a
	wire logic        otp_ff  = part_ff && otp_ok; // R4 R5
	wire logic        otp_00  = part_00 && otp_ok && otp_select_a && !req.extended; // R3 R4 R5

	always_comb begin
		route          = '0;
		route.target   = pmd_pkg::TGT_EXT;
		// Upper four bits drop on the pins
		route.ext_addr = req.addr[pmd_pkg::EXT_W-1:0]; // R23 R1 R7 R8 R14
		route.otp_addr = {pmd_pkg::PAGE_FF, low};
		route.key_area = part_ff && in_rng(low, pmd_pkg::KEY_LO, pmd_pkg::KEY_HI); // R10
		route.vector_area = part_ff && (in_rng(low, pmd_pkg::LVEC_LO, pmd_pkg::KEY_LO - 16'h0001)
			|| in_rng(low, pmd_pkg::UVEC_LO, pmd_pkg::TVEC_HI)); // R9
		if (otp_ff || otp_00) begin
			route.target = pmd_pkg::TGT_OTP;
		end else if (cram_hit && !cram_dis) begin
			route.target = pmd_pkg::TGT_CRAM; // R25
		end else if (psfr || msfr) begin
			route.target = pmd_pkg::TGT_SFR;
			// Windowed access to memory-mapped SFRs is blocked
			route.blocked = msfr && req.window; // R19 R20 R21
		end
		// Key bytes are never written from running code except through the page 00H copy
		if (route.key_area && req.write) begin
			route.blocked = 1'b1; // R10
		end
	end
endmodule : addr_router

// ===== logic/config_latches.sv
`timescale 1ns/1ps
// Holds the three configuration bytes; loads once per reset
module config_latches (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Load strobes from the fetch sequencer
	input  wire logic [2:0] load,
	input  wire logic [7:0] data,
	input  wire logic       done,
	// Latched bytes
	output logic [7:0]      cfg0,
	output logic [7:0]      cfg1,
	output logic [7:0]      cfg2,
	output logic            locked
);
	logic locked_reg; // Set once all bytes are in

	// Each byte takes data only before the lock; later changes are ignored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg0       <= pmd_pkg::CFG_RESET;
			cfg1       <= pmd_pkg::CFG_RESET;
			cfg2       <= pmd_pkg::CFG_RESET;
			locked_reg <= 1'b0;
		end else if (!locked_reg) begin // R12
			if (load[0]) cfg0 <= data; // R11
			if (load[1]) cfg1 <= data;
			if (load[2]) cfg2 <= data;
			if (done) locked_reg <= 1'b1;
		end
	end

	assign locked = locked_reg;

	a_cfg_frozen: assert property (@(posedge clk) disable iff (rst) // R12
		locked_reg |=> $stable(cfg0) && $stable(cfg1) && $stable(cfg2))
		else $error("config latch changed after lock");
endmodule : config_latches

// ===== logic/program_memory_decoder.sv
`timescale 1ns/1ps
// Operation
// R1: One 32K partition, external at F2000-F9FFF
// R2: No internal store: partition always external
// R3: Internal store maps pages 00H+FFH or FFH
// R4: Program area routed by pin, otp_select_a, type
// R5: Special-purpose area uses the same decode
// R6: FF0400-FF05FF goes to internal code RAM
// R7: FF0100-FF03FF goes external as F0100-F03FF
// R8: FF0600-FF1FFF goes external as F0600-F1FFF
// R9: Vector regions in the special-purpose area
// R10: Security key bytes FF2020-FF202F protect store
// R11: Configuration bytes fetched first after reset
// R12: Latches ignore changes until next reset
// R13: Latches select bus, watchdog, mode, otp_select_a
// R14: External configuration fetch at F2018-F201C
// R15: Software fills reserved special bytes
// R16: Software fills unused memory with FFH
// R17: Peripheral SFRs byte/word, windowable
// R18: Marked SFRs accessed only as words
// R19: Memory-mapped SFRs never through window
// R20: Windowed read of them returns FFH
// R21: Windowed write to them does nothing
// R22: Reserved bits read undefined, write zero
// R23: Upper four address bits dropped externally
// R24: Status bit is complement of pin
// R25: Code RAM disable bit routes range external
// R26: Otp_select_a taken from latched byte 2
// R27: Before latching, pin alone steers fetches
module program_memory_decoder (
	// Clock and reset
	input  wire logic              CORE_CLK,
	input  wire logic              RST,
	// Device straps and pins
	input  wire logic              HAS_OTP,
	input  wire logic              EXTERNAL_ACCESS_N,
	// CPU request
	input  pmd_pkg::cpu_req_t      CPU_REQ,
	// Read data returned by the selected target
	input  wire logic [7:0]        MEM_RDATA,
	input  wire logic              MEM_RVALID,
	// Routed request
	output pmd_pkg::route_t        ROUTE,
	output logic                   ROUTE_VALID,
	output logic [7:0]             CPU_RDATA,
	output logic                   CPU_RVALID,
	// Configuration and status
	output logic [7:0]             CONFIG_BYTE_0,
	output logic [7:0]             CONFIG_BYTE_1,
	output logic [7:0]             CONFIG_BYTE_2,
	output logic                   CONFIG_READY,
	output logic                   OTP_SELECT_A,
	output logic [7:0]             CODE_RAM_CONTROL
);
	// Boot fetch sequence, one-hot
	typedef enum logic [4:0] {
		S_F0   = 5'b00001,
		S_F1   = 5'b00010,
		S_F2   = 5'b00100,
		S_RUN  = 5'b01000,
		S_WAIT = 5'b10000
	} boot_t;

	boot_t             state_reg;  // Sequencer state
	boot_t             state_next;
	logic [1:0]        idx_reg;    // Which byte is in flight
	logic [1:0]        idx_next;
	logic              dis_reg;    // Code RAM disable bit
	logic              run_reg;    // Sequencer reached run
	pmd_pkg::cpu_req_t eff_req;    // Request after boot override
	pmd_pkg::route_t   route_w;    // Decoder answer
	logic [2:0]        cfg_load;
	logic              cfg_done;
	logic              cfg_locked;
	logic [7:0]        cfg0;
	logic [7:0]        cfg1;
	logic [7:0]        cfg2;

	// Pin level is active low; status bit shows active
	wire logic ext_active = !EXTERNAL_ACCESS_N; // R24
	// Before the lock the otp_select_a bit is treated as clear
	wire logic otp_select_a_eff  = cfg_locked && cfg2[pmd_pkg::OTP_SELECT_A_BIT]; // R26 R27
	wire logic booting    = (state_reg != S_RUN);
	wire logic [23:0] boot_addr = (idx_reg == 2'd0) ? pmd_pkg::CFG0_ADDR
		: (idx_reg == 2'd1) ? pmd_pkg::CFG1_ADDR : pmd_pkg::CFG2_ADDR; // R11
	wire logic issue      = (state_reg == S_F0) || (state_reg == S_F1) || (state_reg == S_F2);
	wire logic crc_hit    = CPU_REQ.valid && !CPU_REQ.window
		&& (CPU_REQ.addr == {pmd_pkg::PAGE_00, pmd_pkg::CRC_ADDR});
	// Register image; bit 7 live status, bit 6 stored, rest read zero
	wire logic [7:0] crc_image = {ext_active, dis_reg, 6'h00}; // R22

	// Boot fetches replace the CPU request until the latches are loaded
	always_comb begin
		eff_req = CPU_REQ;
		if (booting) begin
			eff_req          = '0;
			eff_req.valid    = issue;
			eff_req.addr     = boot_addr;
			eff_req.extended = 1'b1;
		end
	end

	addr_router u_router (
		.req        (eff_req),
		.has_otp    (HAS_OTP),
		.ext_active (ext_active),
		.otp_select_a      (otp_select_a_eff),
		.cram_dis   (dis_reg),
		.route      (route_w)
	);

	config_latches u_cfg (
		.clk    (CORE_CLK),
		.rst    (RST),
		.load   (cfg_load),
		.data   (MEM_RDATA),
		.done   (cfg_done),
		.cfg0   (cfg0),
		.cfg1   (cfg1),
		.cfg2   (cfg2),
		.locked (cfg_locked)
	);

	// Byte returned while waiting lands in the latch for idx
	assign cfg_load = (state_reg == S_WAIT && MEM_RVALID)
		? (3'b001 << idx_reg) : 3'b000; // R11
	assign cfg_done = (state_reg == S_WAIT) && MEM_RVALID && (idx_reg == 2'd2);

	// Sequencer: issue one byte, wait for its data, move on
	always_comb begin
		state_next = state_reg;
		idx_next   = idx_reg;
		case (state_reg)
			S_F0, S_F1, S_F2: begin
				state_next = S_WAIT;
			end
			S_WAIT: begin
				if (MEM_RVALID) begin
					// Last byte in: hand the bus to the CPU
					if (idx_reg == 2'd2) begin
						state_next = S_RUN;
					end else begin
						idx_next   = idx_reg + 2'd1;
						state_next = (idx_reg == 2'd0) ? S_F1 : S_F2;
					end
				end
			end
			S_RUN: begin
				state_next = S_RUN;
			end
			default: begin
				state_next = S_F0;
				idx_next   = 2'd0;
			end
		endcase
	end

	// Sequencer state flops
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state_reg <= S_F0;
			idx_reg   <= 2'd0;
			run_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
			run_reg   <= (state_next == S_RUN);
		end
	end

	// Code RAM control write; windowed writes never land here
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			dis_reg <= pmd_pkg::CRC_RESET[pmd_pkg::CRC_DISABLE];
		end else if (!booting && crc_hit && CPU_REQ.write) begin
			dis_reg <= CPU_REQ.wdata[pmd_pkg::CRC_DISABLE]; // R25 R21
		end
	end

	// Registered route out; the routed target answers the CPU
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ROUTE       <= '0;
			ROUTE_VALID <= 1'b0;
		end else begin
			ROUTE       <= route_w;
			ROUTE_VALID <= eff_req.valid && !route_w.blocked; // R21
		end
	end

	// Read return: blocked window reads see all ones, own register local
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			CPU_RDATA  <= 8'h00;
			CPU_RVALID <= 1'b0;
		end else if (!booting && CPU_REQ.valid && !CPU_REQ.write && route_w.blocked) begin
			CPU_RDATA  <= pmd_pkg::WINDOW_FILL; // R20
			CPU_RVALID <= 1'b1;
		end else if (!booting && crc_hit && !CPU_REQ.write) begin
			CPU_RDATA  <= crc_image; // R24
			CPU_RVALID <= 1'b1;
		end else begin
			CPU_RDATA  <= MEM_RDATA;
			CPU_RVALID <= !booting && MEM_RVALID;
		end
	end

	// Configuration outputs mirror the latches
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			CONFIG_BYTE_0    <= pmd_pkg::CFG_RESET;
			CONFIG_BYTE_1    <= pmd_pkg::CFG_RESET;
			CONFIG_BYTE_2    <= pmd_pkg::CFG_RESET;
			CONFIG_READY     <= 1'b0;
			OTP_SELECT_A     <= 1'b0;
			CODE_RAM_CONTROL <= pmd_pkg::CRC_RESET;
		end else begin
			CONFIG_BYTE_0    <= cfg0; // R13
			CONFIG_BYTE_1    <= cfg1;
			CONFIG_BYTE_2    <= cfg2;
			CONFIG_READY     <= cfg_locked;
			OTP_SELECT_A     <= otp_select_a_eff; // R26
			CODE_RAM_CONTROL <= crc_image;
		end
	end

	// Checks
	a_boot_ext_addr: assert property (@(posedge CORE_CLK) disable iff (RST) // R14
		issue |-> route_w.ext_addr == boot_addr[19:0])
		else $error("boot fetch address wrong");
	a_pin_forces_ext: assert property (@(posedge CORE_CLK) disable iff (RST) // R4
		ext_active && eff_req.valid |-> route_w.target != pmd_pkg::TGT_OTP)
		else $error("internal store used with pin active");
	a_no_otp_part: assert property (@(posedge CORE_CLK) disable iff (RST) // R2
		!HAS_OTP |-> route_w.target != pmd_pkg::TGT_OTP)
		else $error("internal store used on variant without it");
	a_window_fill: assert property (@(posedge CORE_CLK) disable iff (RST) // R20
		!booting && CPU_REQ.valid && CPU_REQ.window && !CPU_REQ.write
		&& CPU_REQ.addr[23:5] == 19'h000ff |=> CPU_RVALID && CPU_RDATA == 8'hff)
		else $error("windowed mapped read not all ones");
	a_window_nowrite: assert property (@(posedge CORE_CLK) disable iff (RST) // R21
		CPU_REQ.valid && CPU_REQ.window |=> $stable(dis_reg))
		else $error("windowed write changed register");
	// The register image is forced to zero in reset, so the edge just after release is skipped
	a_status_pin: assert property (@(posedge CORE_CLK) disable iff (RST) // R24
		!$past(RST) |-> CODE_RAM_CONTROL[7] == !$past(EXTERNAL_ACCESS_N))
		else $error("status bit not complement of pin");
	a_cram_route: assert property (@(posedge CORE_CLK) disable iff (RST) // R6
		!booting && CPU_REQ.valid && CPU_REQ.addr[23:9] == 15'h7f82 && !dis_reg
		|-> route_w.target == pmd_pkg::TGT_CRAM)
		else $error("code RAM range misrouted");
	a_boot_done: assert property (@(posedge CORE_CLK) disable iff (RST) // R11
		run_reg |-> cfg_locked)
		else $error("run reached before latches loaded");
	a_ext_pages: assert property (@(posedge CORE_CLK) disable iff (RST) // R7
		!booting && CPU_REQ.valid && CPU_REQ.addr[23:8] == 16'hff01
		|-> route_w.target == pmd_pkg::TGT_EXT && route_w.ext_addr == CPU_REQ.addr[19:0])
		else $error("page FFH low external range misrouted");
	// Upper external block of page FFH keeps its low 20 bits on the pins
	a_ext_high: assert property (@(posedge CORE_CLK) disable iff (RST) // R8
		!booting && CPU_REQ.valid && CPU_REQ.addr[23:12] == 12'hff1
		|-> route_w.target == pmd_pkg::TGT_EXT && route_w.ext_addr == CPU_REQ.addr[19:0])
		else $error("page FFH high external range misrouted");
	// Disabled code RAM hands its range to the external bus
	a_ram_off_ext: assert property (@(posedge CORE_CLK) disable iff (RST) // R25
		!booting && CPU_REQ.valid && CPU_REQ.addr[23:9] == 15'h7f82 && dis_reg
		|-> route_w.target == pmd_pkg::TGT_EXT)
		else $error("disabled code RAM range not external");
	// Before the lock only the pin and the variant choose where fetches go
	a_boot_store: assert property (@(posedge CORE_CLK) disable iff (RST) // R27
		issue && HAS_OTP && !ext_active |-> route_w.target == pmd_pkg::TGT_OTP)
		else $error("boot fetch not served by internal store");
	// Plain fetches with otp_select_a set see the store copy in page 00H
	a_copy_store: assert property (@(posedge CORE_CLK) disable iff (RST) // R3
		!booting && CPU_REQ.valid && HAS_OTP && !ext_active && otp_select_a_eff && !CPU_REQ.extended
		&& CPU_REQ.addr[23:16] == 8'h00 && CPU_REQ.addr[15:13] != 3'd0
		&& CPU_REQ.addr[15:13] <= 3'd4 |-> route_w.target == pmd_pkg::TGT_OTP)
		else $error("page 00H copy not served by store");
	// Without otp_select_a, or for extended accesses, the page 00H range stays external
	a_copy_ext: assert property (@(posedge CORE_CLK) disable iff (RST) // R4
		!booting && CPU_REQ.valid && (!otp_select_a_eff || CPU_REQ.extended)
		&& CPU_REQ.addr[23:16] == 8'h00 && CPU_REQ.addr[15:13] != 3'd0
		&& CPU_REQ.addr[15:13] <= 3'd4 |-> route_w.target == pmd_pkg::TGT_EXT)
		else $error("page 00H partition misrouted");
	// Key writes in page FFH never leave the decoder
	a_key_block: assert property (@(posedge CORE_CLK) disable iff (RST) // R10
		!booting && CPU_REQ.valid && CPU_REQ.write && CPU_REQ.addr[23:4] == 20'hff202
		|=> !ROUTE_VALID && ROUTE.blocked)
		else $error("key write forwarded");
	// Peripheral registers stay reachable through the window
	a_psfr_pass: assert property (@(posedge CORE_CLK) disable iff (RST) // R17
		!booting && CPU_REQ.valid && CPU_REQ.window && CPU_REQ.addr[23:8] == 16'h001f
		&& CPU_REQ.addr[7:5] != 3'b111 |=> ROUTE_VALID && ROUTE.target == pmd_pkg::TGT_SFR)
		else $error("windowed peripheral access refused");
	// Otp_select_a output follows the latched byte only once it is loaded
	a_otp_select_a_out: assert property (@(posedge CORE_CLK) disable iff (RST) // R26
		OTP_SELECT_A == (CONFIG_READY && CONFIG_BYTE_2[pmd_pkg::OTP_SELECT_A_BIT]))
		else $error("otp_select_a output not from latched byte");
endmodule : program_memory_decoder

// ===== verification/mem_partner.sv
`timescale 1ns/1ps
// Memory controller and external bus stand-in: answers the newest forwarded access
module mem_partner (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst,
	// Routed request from the decoder
	input  pmd_pkg::route_t      route,
	input  wire logic            route_valid,
	// Answer delay in cycles, 0 is prompt
	input  wire logic [1:0]      dly,
	// Configuration byte 2 image handed out at its fetch
	input  wire logic [7:0]      cfg2_img,
	// Answer
	output logic [7:0]           rdata,
	output logic                 rvalid
);
	logic [19:0] addr_reg;  // Address of the pending access
	logic [1:0]  wait_reg;  // Cycles left before answering
	logic        busy_reg;  // An access is outstanding
	wire  [19:0] addr_now;  // Address as the target sees it

	// External target sees the bus address, internal ones the low bits
	assign addr_now = (route.target == pmd_pkg::TGT_EXT) ? route.ext_addr : route.otp_addr[19:0];

	// Stored image: configuration bytes and their reserved neighbours
	function automatic logic [7:0] content(input logic [19:0] a);
		case (a[15:0])
			16'h2018: return 8'ha5;
			16'h201a: return 8'h3c;
			16'h201c: return cfg2_img;
			16'h2019, 16'h201b, 16'h201d: return 8'h20;
			default: return 8'hff;
		endcase
	endfunction : content

	// One access at a time; a newer request replaces a pending one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr_reg <= 20'h00000;
			wait_reg <= 2'd0;
			busy_reg <= 1'b0;
			rdata    <= 8'h00;
			rvalid   <= 1'b0;
		end else begin
			rvalid <= 1'b0;
			// Idle data toggles so a stale byte is never mistaken for an answer
			rdata  <= ~rdata;
			if (route_valid) begin
				busy_reg <= 1'b1;
				wait_reg <= dly;
				addr_reg <= addr_now;
			end else if (busy_reg && wait_reg == 2'd0) begin
				busy_reg <= 1'b0;
				rvalid   <= 1'b1;
				rdata    <= content(addr_reg);
			end else if (busy_reg) begin
				wait_reg <= wait_reg - 2'd1;
			end
		end
	end
endmodule : mem_partner

// ===== verification/testbench.sv
`timescale 1ns/1ps
// Self-checking bench: boots the decoder, then walks the address map
module testbench;
	logic              core_clk;    // 250 MHz core clock
	logic              rst;         // Async reset, active high
	logic              has_otp;     // Internal store fitted
	logic              ext_n;       // External-access pin, low = external
	pmd_pkg::cpu_req_t cpu_req;     // CPU request
	logic [7:0]        mem_rdata;   // Partner answer data
	logic              mem_rvalid;  // Partner answer strobe
	pmd_pkg::route_t   route;       // Decode result
	logic              route_valid; // Request forwarded
	logic [7:0]        cpu_rdata;   // Read answer
	logic              cpu_rvalid;  // Read answer strobe
	logic [7:0]        cfg0;        // Latched configuration bytes
	logic [7:0]        cfg1;
	logic [7:0]        cfg2;
	logic              cfg_ready;   // Latches loaded
	logic              otp_select_a;       // Effective otp_select_a
	logic [7:0]        crc;         // Code RAM control register
	logic [1:0]        dly;         // Partner answer delay
	logic [7:0]        cfg2_img;    // Configuration byte 2 held by the partner
	int                wait_n;      // Cycles spent waiting for a read answer
	int                err_count;   // Mismatches
	int                checked;     // Comparisons made
	int                cycles;      // Run length so far
	// Address map table: address, extended flag, expected target
	logic [23:0] map_a [12] = '{24'hff0200, 24'hff03ff, 24'hff0400, 24'hff05ff, 24'hff0600,
		24'hff1fff, 24'hff2080, 24'hff9fff, 24'h002080, 24'h00207f, 24'hff2000, 24'h002080};
	logic        map_x [12] = '{1, 1, 1, 1, 1, 1, 1, 1, 0, 0, 1, 1};
	logic [3:0]  map_t [12] = '{1, 1, 4, 4, 1, 1, 2, 2, 2, 2, 2, 1};

	program_memory_decoder i_dut (.CORE_CLK(core_clk), .RST(rst), .HAS_OTP(has_otp),
		.EXTERNAL_ACCESS_N(ext_n), .CPU_REQ(cpu_req), .MEM_RDATA(mem_rdata),
		.MEM_RVALID(mem_rvalid), .ROUTE(route), .ROUTE_VALID(route_valid),
		.CPU_RDATA(cpu_rdata), .CPU_RVALID(cpu_rvalid), .CONFIG_BYTE_0(cfg0),
		.CONFIG_BYTE_1(cfg1), .CONFIG_BYTE_2(cfg2), .CONFIG_READY(cfg_ready),
		.OTP_SELECT_A(otp_select_a), .CODE_RAM_CONTROL(crc));

	mem_partner i_mem (.clk(core_clk), .rst(rst), .route(route), .route_valid(route_valid),
		.dly(dly), .cfg2_img(cfg2_img), .rdata(mem_rdata), .rvalid(mem_rvalid));

	// Clock
	always #2 core_clk = ~core_clk;

	// Hang guard, well beyond the few hundred cycles the run needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			conclude();
		end
	end

	// Compare one observed value with its expectation
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Verdict and end of run
	task automatic conclude();
		if (err_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	// One CPU request held for one cycle; outputs are settled on return
	task automatic req(input logic [23:0] a, input logic ex, win, wr, input logic [7:0] wd);
		@(posedge core_clk);
		#1;
		// The timer counter is word-only, so software only ever reaches it as a word
		cpu_req = '{1'b1, a, ex, win, wr, (a[15:0] == 16'h1f9e), wd};
		@(posedge core_clk);
		#1;
		cpu_req.valid = 1'b0;
	endtask : req

	// Reset, watch the first configuration fetch, wait for the latches
	task automatic boot(input logic pin, otp, input logic [1:0] d, input logic [3:0] tgt);
		int n;
		@(posedge core_clk);
		#1;
		rst = 1'b1;
		ext_n = pin;
		has_otp = otp;
		dly = d;
		repeat (16) @(posedge core_clk);
		chk("reset state", {cfg0, cfg1, cfg2, crc}, 32'hffffff00);
		#1;
		rst = 1'b0;
		n = 0;
		while (route_valid !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk("first fetch target", 32'(route.target), 32'(tgt));
		if (tgt == 4'h1)
			chk("first fetch addr", 32'(route.ext_addr), 32'h000f2018);
		n = 0;
		while (cfg_ready !== 1'b1 && n < 200) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk("config bytes", {cfg0, cfg1, cfg2, 7'h00, cfg_ready},
			{16'ha53c, cfg2_img, 8'h01});
		chk("otp_select_a", 32'(otp_select_a), 32'(cfg2_img[pmd_pkg::OTP_SELECT_A_BIT]));
	endtask : boot

	// Main sequence
	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		has_otp = 1'b1;
		ext_n = 1'b1;
		cpu_req = '0;
		dly = 2'd0;
		cfg2_img = 8'h04;
		err_count = 0;
		checked = 0;
		cycles = 0;
		boot(1'b0, 1'b1, 2'd0, 4'h1);
		// Slow answers keep late read data clear of the checked cycles
		dly = 2'd3;
		chk("status pin low", 32'(crc), 32'h80);
		ext_n = 1'b1;
		@(posedge core_clk);
		#1;
		chk("status pin high", 32'(crc), 32'h00);
		for (int i = 0; i < 12; i++) begin
			req(map_a[i], map_x[i], 1'b0, 1'b0, 8'h00);
			chk("map target", 32'(route.target), 32'(map_t[i]));
			if (map_t[i] == 4'h1)
				chk("map ext addr", 32'(route.ext_addr), {12'h000, map_a[i][19:0]});
			if (map_t[i] == 4'h2)
				chk("map store addr", 32'(route.otp_addr),
					{16'h00ff, map_a[i][15:0]});
		end
		ext_n = 1'b0;
		req(24'hff9fff, 1'b1, 1'b0, 1'b0, 8'h00);
		chk("ext program", {route.target, route.ext_addr}, 32'h001f9fff);
		req(24'hff207f, 1'b1, 1'b0, 1'b0, 8'h00);
		chk("ext special", {route.target, route.ext_addr}, 32'h001f207f);
		ext_n = 1'b1;
		req(24'hff2020, 1'b1, 1'b0, 1'b1, 8'h00);
		chk("key write", {route.blocked, route_valid}, 32'h2);
		req(24'hff202f, 1'b1, 1'b0, 1'b0, 8'h00);
		chk("key area", 32'(route.key_area), 32'h1);
		req(24'hff2040, 1'b1, 1'b0, 1'b0, 8'h00);
		chk("vector area", 32'(route.vector_area), 32'h1);
		req(24'hff201c, 1'b1, 1'b0, 1'b1, 8'h00);
		chk("latch held", 32'(cfg2), 32'h04);
		req(24'h001f9e, 1'b0, 1'b1, 1'b0, 8'h00);
		chk("peripheral window", {route.target, route.blocked, route_valid}, 32'h21);
		req(24'h001fe0, 1'b0, 1'b1, 1'b0, 8'h00);
		chk("window read", {cpu_rvalid, cpu_rdata, route_valid, route.blocked}, 32'h7fd);
		req(24'h001fe0, 1'b0, 1'b1, 1'b1, 8'h40);
		@(posedge core_clk);
		#1;
		chk("window write", 32'(crc), 32'h00);
		req(24'h001fe0, 1'b0, 1'b0, 1'b1, 8'hff);
		@(posedge core_clk);
		#1;
		chk("ram disable", 32'(crc), 32'h40);
		req(24'h001fe0, 1'b0, 1'b0, 1'b0, 8'h00);
		chk("control read", {cpu_rvalid, cpu_rdata}, 32'h140);
		req(24'hff0500, 1'b1, 1'b0, 1'b0, 8'h00);
		chk("ram off route", {route.target, route.ext_addr}, 32'h001f0500);
		// A store read comes back through the partner a few cycles later
		req(24'hff201a, 1'b1, 1'b0, 1'b0, 8'h00);
		for (wait_n = 0; wait_n < 12 && cpu_rvalid !== 1'b1; wait_n++) begin
			@(posedge core_clk);
			#1;
		end
		chk("store read", {cpu_rvalid, cpu_rdata}, 32'h13c);
		req(24'h001fe0, 1'b0, 1'b0, 1'b1, 8'h00);
		chk("config kept", {cfg0, cfg1, cfg2}, 32'ha53c04);
		boot(1'b1, 1'b1, 2'd3, 4'h2);
		boot(1'b1, 1'b0, 2'd1, 4'h1);
		req(24'hff3000, 1'b1, 1'b0, 1'b0, 8'h00);
		chk("no store route", {route.target, route.ext_addr}, 32'h001f3000);
		// Boot again with otp_select_a clear: the page 00H copy goes away
		cfg2_img = 8'h00;
		boot(1'b1, 1'b1, 2'd0, 4'h2);
		req(24'h002080, 1'b0, 1'b0, 1'b0, 8'h00);
		chk("no copy route", {route.target, route.ext_addr}, 32'h00102080);
		req(24'hff2080, 1'b1, 1'b0, 1'b0, 8'h00);
		chk("store page ff", 32'(route.target), 32'h2);
		conclude();
	end
endmodule : testbench
